// ---- inc/acr_defines.vh ----
// offsets, field positions, reset values and op encodings of the rounding alu
// assumes inclusion by the design file under core/ and the bench under test/
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH
// register map, byte addresses on the plain register port
`define ACR_ADDR_STATUS 8'h00
`define ACR_ADDR_HALF 8'h04
// arithmetic_status_reg field positions
`define ACR_ST_AZ 0
`define ACR_ST_AN 1
`define ACR_ST_CC 5
`define ACR_ST_AQ 6
`define ACR_ST_RBS 8
`define ACR_ST_AV0 12
`define ACR_ST_ALU0_STICKY_OVERFLOW 13
`define ACR_ST_AV1 14
`define ACR_ST_ALU1_STICKY_OVERFLOW 15
`define ACR_ST_V 24
`define ACR_ST_VS 25
`define ACR_ST_WMASK 32'h0300_f163
`define ACR_ST_RESET 32'h0000_0000
// operation codes
`define ACR_OP_ADD 4'h0
`define ACR_OP_SUB 4'h1
`define ACR_OP_ADDI 4'h2
`define ACR_OP_SUBI 4'h3
`define ACR_OP_ACC 4'h4
`define ACR_OP_AND 4'h5
`define ACR_OP_OR 4'h6
`define ACR_OP_XOR 4'h7
`define ACR_OP_NOT 4'h8
`define ACR_OP_NEG 4'h9
`define ACR_OP_ABS 4'ha
`define ACR_OP_MAX 4'hb
`define ACR_OP_MIN 4'hc
`define ACR_OP_RND 4'hd
`define ACR_OP_DIVS 4'he
`define ACR_OP_DIVQ 4'hf
// operand and result widths
`define ACR_W16 2'h0
`define ACR_W32 2'h1
`define ACR_W40 2'h2
// rounding options
`define ACR_RND_NONE 2'h0
`define ACR_RND_16 2'h1
`define ACR_RND_12 2'h2
`define ACR_RND_20 2'h3
// rounding boundary bit positions
`define ACR_BND_12 6'd12
`define ACR_BND_16 6'd16
`define ACR_BND_20 6'd20
// the midway pattern of the discarded low half
`define ACR_TIE_16 16'h8000
`endif

// ---- core/acr_round_alu.v ----
// rounding and truncating fixed-point alu with arithmetic status register
// assumes op inputs and register port come from logic on core_clk
`timescale 1ns/1ps
`include "acr_defines.vh"

module acr_round_alu (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // operation request
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [1:0] op_width,
  input wire op_sat,
  input wire [1:0] op_round,
  input wire op_alu1,
  input wire [39:0] op_src_a,
  input wire [39:0] op_src_b,
  input wire [6:0] op_imm,
  input wire [39:0] acc_in,
  // results
  output reg res_valid_r,
  output reg [39:0] res_full_r,
  output reg [15:0] res_half_r,
  output reg [39:0] round_sum_r,
  output reg acc_wr_r,
  output reg [39:0] acc_out_r,
  output reg condition_code_flag_r,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_r
);

  reg [31:0] stat_r;
  reg [31:0] stat_nxt;
  reg [31:0] rdata_nxt;
  reg [39:0] opb;
  reg [40:0] raw;
  reg arith;
  reg ov;
  reg [39:0] res40;
  reg [39:0] sat32;
  reg [39:0] rsrc;
  reg [39:0] rsum;
  reg [39:0] rshift;
  reg [5:0] bnd;
  reg [15:0] half;
  reg half_ov;
  reg half_path;
  reg aq_new;
  reg [16:0] divq_up;
  reg cc_new;
  reg cc_upd;
  wire rbs;

  assign rbs = stat_r[`ACR_ST_RBS];

  // operand b: immediates are sign-extended 7-bit values
  always @* begin
    if (op_code == `ACR_OP_ADDI || op_code == `ACR_OP_SUBI) begin
      opb = {{33{op_imm[6]}}, op_imm};
    end else begin
      opb = op_src_b;
    end
  end

  // exact 41-bit operation result
  always @* begin
    raw = 41'h0;
    arith = 1'b0;
    aq_new = stat_r[`ACR_ST_AQ];
    divq_up = 17'h0;
    cc_upd = 1'b0;
    case (op_code)
      `ACR_OP_ADD, `ACR_OP_ADDI: begin
        raw = {op_src_a[39], op_src_a} + {opb[39], opb};
        arith = 1'b1;
      end
      `ACR_OP_SUB, `ACR_OP_SUBI: begin
        raw = {op_src_a[39], op_src_a} - {opb[39], opb};
        arith = 1'b1;
        cc_upd = 1'b1;
      end
      `ACR_OP_ACC: begin
        raw = {acc_in[39], acc_in} + {opb[39], opb};
        arith = 1'b1;
      end
      `ACR_OP_AND: raw = {1'b0, op_src_a & opb};
      `ACR_OP_OR: raw = {1'b0, op_src_a | opb};
      `ACR_OP_XOR: raw = {1'b0, op_src_a ^ opb};
      `ACR_OP_NOT: raw = {1'b0, ~op_src_a};
      `ACR_OP_NEG: begin
        raw = 41'h0 - {op_src_a[39], op_src_a};
        arith = 1'b1;
      end
      `ACR_OP_ABS: begin
        raw = op_src_a[39] ? 41'h0 - {1'b1, op_src_a} : {1'b0, op_src_a};
        arith = 1'b1;
      end
      `ACR_OP_MAX: begin
        raw = ($signed(op_src_a) > $signed(opb)) ? {op_src_a[39], op_src_a} : {opb[39], opb};
      end
      `ACR_OP_MIN: begin
        raw = ($signed(op_src_a) < $signed(opb)) ? {op_src_a[39], op_src_a} : {opb[39], opb};
      end
      `ACR_OP_RND: raw = {op_src_a[39], op_src_a};
      `ACR_OP_DIVS: begin
        // sign primitive: quotient sign into aq, dividend shifted left
        aq_new = op_src_a[31] ^ opb[15];
        raw = {9'h0, op_src_a[30:0], op_src_a[31] ^ opb[15]};
      end
      `ACR_OP_DIVQ: begin
        // one non-restoring quotient step on the upper half
        divq_up = stat_r[`ACR_ST_AQ] ? {1'b0, op_src_a[31:16]} + {1'b0, opb[15:0]}
                                     : {1'b0, op_src_a[31:16]} - {1'b0, opb[15:0]};
        aq_new = divq_up[15] ^ opb[15];
        raw = {9'h0, divq_up[14:0], op_src_a[15:0], ~(divq_up[15] ^ opb[15])};
      end
      default: raw = 41'h0;
    endcase
  end

  // width fit and optional saturation
  always @* begin
    ov = 1'b0;
    res40 = raw[39:0];
    case (op_width)
      `ACR_W16: begin
        ov = arith & ~((&raw[40:15]) | ~(|raw[40:15]));
        if (ov & op_sat) begin
          res40 = raw[40] ? 40'hff_ffff_8000 : 40'h00_0000_7fff;
        end else begin
          res40 = {{24{raw[15]}}, raw[15:0]};
        end
      end
      `ACR_W32: begin
        ov = arith & ~((&raw[40:31]) | ~(|raw[40:31]));
        if (ov & op_sat) begin
          res40 = raw[40] ? 40'hff_8000_0000 : 40'h00_7fff_ffff;
        end else begin
          res40 = {{8{raw[31]}}, raw[31:0]};
        end
      end
      default: begin
        ov = arith & (raw[40] ^ raw[39]);
        if (ov & op_sat) begin
          res40 = raw[40] ? 40'h80_0000_0000 : 40'h7f_ffff_ffff;
        end else begin
          res40 = raw[39:0];
        end
      end
    endcase
  end

  // 32-bit saturation ahead of the 12 and 20 boundaries
  always @* begin
    if ((&raw[40:31]) | ~(|raw[40:31])) begin
      sat32 = {{8{raw[31]}}, raw[31:0]};
    end else begin
      sat32 = raw[40] ? 40'hff_8000_0000 : 40'h00_7fff_ffff;
    end
  end

  // rounding adder and half extraction
  always @* begin
    rsrc = res40;
    bnd = `ACR_BND_16;
    rsum = res40;
    half_path = (op_width != `ACR_W16) | (op_code == `ACR_OP_RND);
    case (op_round)
      `ACR_RND_16: begin
        // one into bit 15, full 40-bit value
        rsum = res40 + 40'h00_0000_8000;
        if (~rbs && res40[15:0] == `ACR_TIE_16) begin
          rsum[16] = 1'b0; // ties to even only when unbiased
        end
        // biased tie over an even upper part keeps the midway pattern in the sum
        if (rbs && res40[15:0] == `ACR_TIE_16 && ~res40[16]) begin
          rsum[15:0] = `ACR_TIE_16;
        end
      end
      `ACR_RND_12: begin
        rsrc = sat32;
        bnd = `ACR_BND_12;
        rsum = sat32 + 40'h00_0000_0800; // always biased
      end
      `ACR_RND_20: begin
        rsrc = sat32;
        bnd = `ACR_BND_20;
        rsum = sat32 + 40'h00_0008_0000; // always biased
      end
      default: rsum = rsrc; // plain truncation, bias select unused
    endcase
    rshift = $signed(rsum) >>> bnd;
    // 16-bit non-round ops skip the adder, so v stays clear there
    if (half_path) begin
      half = rshift[15:0]; // bits just above the boundary
      half_ov = ~((&rshift[39:15]) | ~(|rshift[39:15]));
    end else begin
      half = res40[15:0];
      half_ov = 1'b0;
    end
  end

  // condition code: signed less-than after a subtract
  always @* begin
    cc_new = stat_r[`ACR_ST_CC];
    if (cc_upd) begin
      cc_new = raw[40];
    end
  end

  // status register: software write first, then hardware update on top
  always @* begin
    stat_nxt = stat_r;
    if (reg_wr && reg_addr == `ACR_ADDR_STATUS) begin
      stat_nxt = reg_wdata & `ACR_ST_WMASK; // clears stickies too
    end
    // update applied last so a flag event is never lost to a write
    if (op_valid) begin
      // latest operation owns the flags
      stat_nxt[`ACR_ST_AZ] = (res40 == 40'h0);
      stat_nxt[`ACR_ST_AN] = res40[39];
      stat_nxt[`ACR_ST_CC] = cc_new;
      stat_nxt[`ACR_ST_AQ] = aq_new;
      stat_nxt[`ACR_ST_V] = half_ov;
      // sticky sets win over a same-cycle clear
      stat_nxt[`ACR_ST_VS] = stat_nxt[`ACR_ST_VS] | half_ov;
      if (op_alu1) begin
        stat_nxt[`ACR_ST_AV1] = ov;
        stat_nxt[`ACR_ST_ALU1_STICKY_OVERFLOW] = stat_nxt[`ACR_ST_ALU1_STICKY_OVERFLOW] | ov;
      end else begin
        stat_nxt[`ACR_ST_AV0] = ov;
        stat_nxt[`ACR_ST_ALU0_STICKY_OVERFLOW] = stat_nxt[`ACR_ST_ALU0_STICKY_OVERFLOW] | ov;
      end
    end
  end

  // register read data, unmapped addresses read zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `ACR_ADDR_STATUS: rdata_nxt = stat_r;
        `ACR_ADDR_HALF: rdata_nxt = {16'h0000, res_half_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_r <= `ACR_ST_RESET;
      reg_rdata_r <= 32'h0000_0000;
      res_valid_r <= 1'b0;
      res_full_r <= 40'h0;
      res_half_r <= 16'h0000;
      round_sum_r <= 40'h0;
      acc_wr_r <= 1'b0;
      acc_out_r <= 40'h0;
      condition_code_flag_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      reg_rdata_r <= rdata_nxt;
      condition_code_flag_r <= stat_nxt[`ACR_ST_CC];
      res_valid_r <= op_valid;
      acc_wr_r <= op_valid & (op_code == `ACR_OP_ACC);
      if (op_valid) begin
        res_full_r <= res40;
        round_sum_r <= rsum;
        res_half_r <= half; // rounded value to destination only
        if (op_code == `ACR_OP_ACC) begin
          acc_out_r <= res40; // accumulator keeps unrounded sum
        end
      end
    end
  end

endmodule

// ---- test/acr_round_alu_checker.sv ----
// port assertions for the rounding alu
// assumes one core_clk domain with sys_rst active high
`timescale 1ns/1ps
module acr_round_alu_checker (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // operation request
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [1:0] op_width,
  input wire op_sat,
  input wire [1:0] op_round,
  input wire [39:0] op_src_a,
  input wire [39:0] op_src_b,
  input wire [39:0] acc_in,
  // results
  input wire res_valid_r,
  input wire [15:0] res_half_r,
  input wire [39:0] round_sum_r,
  input wire acc_wr_r,
  input wire [39:0] acc_out_r,
  // register port
  input wire reg_rd,
  input wire [31:0] reg_rdata_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // 40-bit pass request, so the source is the operand itself, saturated to 32 bits at the 12 and 20 boundaries
  sequence wide_req(rnd);
    op_valid && op_code == 4'hd && op_width == 2'h2 && op_round == rnd;
  endsequence
  chk_res_follows: assert property (op_valid |=> res_valid_r)
    else $error("no result after op");
  chk_res_idle: assert property (!op_valid |=> !res_valid_r)
    else $error("stray result pulse");
  chk_read_idle: assert property (!reg_rd |=> reg_rdata_r == 32'h0)
    else $error("read data lingers");
  chk_trunc_half: assert property (
    wide_req(2'h0) |=> res_half_r == $past(op_src_a[31:16]))
    else $error("truncated half wrong");
  chk_round_add: assert property (
    wide_req(2'h1) ##0 op_src_a[15:0] != 16'h8000 |=> round_sum_r == $past(op_src_a) + 40'h8000)
    else $error("round sum wrong");
  chk_round_pick: assert property (wide_req(2'h1) |=> res_half_r == round_sum_r[31:16])
    else $error("half not above boundary");
  chk_round_twelve: assert property (
    wide_req(2'h2) ##0 op_src_a[39:31] == 9'h0
    |=> res_half_r == 16'(($past(op_src_a) + 40'h800) >> 12))
    else $error("round at 12 wrong");
  chk_acc_unround: assert property (
    op_valid && op_code == 4'h4 && op_width == 2'h2 && !op_sat
    |=> acc_wr_r && acc_out_r == $past(acc_in) + $past(op_src_b))
    else $error("accumulator value wrong");
endmodule
bind acr_round_alu acr_round_alu_checker chk (.core_clk, .sys_rst, .op_valid, .op_code,
  .op_width, .op_sat, .op_round, .op_src_a, .op_src_b, .acc_in, .res_valid_r, .res_half_r,
  .round_sum_r, .acc_wr_r, .acc_out_r, .reg_rd, .reg_rdata_r);

// ---- test/accumulator_result_rounding_test.sv ----
// self-checking bench for the rounding alu
// assumes the design under core/ with the checker bound to it
`timescale 1ns/1ps
`include "acr_defines.vh"
module accumulator_result_rounding_test;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  logic [3:0] op_code = 4'h0;
  logic [1:0] op_width = 2'h2;
  logic op_alu1 = 1'b0;
  logic op_sat = 1'b0;
  logic [1:0] op_round = 2'h0;
  logic [39:0] op_src_a = 40'h0;
  logic [39:0] op_src_b = 40'h0;
  logic [39:0] acc_in = 40'h1000;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic also_wr = 1'b0;
  wire res_valid_r, acc_wr_r, condition_code_flag_r;
  wire [39:0] res_full_r, round_sum_r, acc_out_r;
  wire [15:0] res_half_r;
  wire [31:0] reg_rdata_r;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  typedef struct {logic [3:0] c; logic [1:0] r; logic [39:0] a, b, sb, su;} acr_row_t;
  acr_row_t rows [26];
  acr_round_alu dut (.core_clk, .sys_rst, .op_valid, .op_code, .op_width, .op_sat,
    .op_round, .op_alu1, .op_src_a, .op_src_b, .op_imm(op_src_b[6:0]), .acc_in, .res_valid_r,
    .res_full_r, .res_half_r, .round_sum_r, .acc_wr_r, .acc_out_r, .condition_code_flag_r,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r);
  always #5 core_clk = ~core_clk;
  task close_out;
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata_r;
  endtask
  // also_wr lets a status write land in the op cycle
  task op(input logic [3:0] c, input logic [1:0] r, input logic [39:0] a, input logic [39:0] b);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_round <= r;
    op_src_a <= a;
    op_src_b <= b;
    reg_wr <= also_wr;
    @(posedge core_clk);
    op_valid <= 1'b0;
    reg_wr <= 1'b0;
    #1;
  endtask
  function automatic logic [15:0] half_of(input logic [1:0] r, input logic [39:0] s);
    case (r)
      2'h2: half_of = s[27:12];
      2'h3: half_of = s[35:20];
      default: half_of = s[31:16];
    endcase
  endfunction
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    logic [31:0] d;
    rows = '{'{4'hd, 2'h1, 40'h8000, 40'h0, 40'h18000, 40'h0},
      '{4'hd, 2'h1, 40'h18000, 40'h0, 40'h20000, 40'h20000},
      '{4'hd, 2'h1, 40'h8001, 40'h0, 40'h10001, 40'h10001},
      '{4'hd, 2'h1, 40'h18001, 40'h0, 40'h20001, 40'h20001},
      '{4'hd, 2'h1, 40'h7fff, 40'h0, 40'hffff, 40'hffff},
      '{4'hd, 2'h1, 40'h17fff, 40'h0, 40'h1ffff, 40'h1ffff},
      '{4'hd, 2'h0, 40'h80008000, 40'h0, 40'h80008000, 40'h80008000},
      '{4'hd, 2'h2, 40'h800, 40'h0, 40'h1000, 40'h1000},
      '{4'hd, 2'h3, 40'h80000, 40'h0, 40'h100000, 40'h100000},
      '{4'hd, 2'h3, 40'h100000000, 40'h0, 40'h8007ffff, 40'h8007ffff},
      '{4'h0, 2'h1, 40'h10000, 40'h4000, 40'h1c000, 40'h1c000},
      '{4'h4, 2'h0, 40'h0, 40'h20, 40'h1020, 40'h1020},
      '{4'h1, 2'h0, 40'h5, 40'h7, 40'hff_ffff_fffe, 40'hff_ffff_fffe},
      '{4'h5, 2'h0, 40'hf0f0, 40'hff00, 40'hf000, 40'hf000},
      '{4'h6, 2'h0, 40'hf0f0, 40'h0f00, 40'hfff0, 40'hfff0},
      '{4'h7, 2'h0, 40'hff00, 40'h0ff0, 40'hf0f0, 40'hf0f0},
      '{4'h8, 2'h0, 40'hffff0000, 40'h0, 40'hff_0000_ffff, 40'hff_0000_ffff},
      '{4'h9, 2'h0, 40'h5, 40'h0, 40'hff_ffff_fffb, 40'hff_ffff_fffb},
      '{4'ha, 2'h0, 40'hff_ffff_fffb, 40'h0, 40'h5, 40'h5},
      '{4'hb, 2'h0, 40'hff_ffff_ffff, 40'h3, 40'h3, 40'h3},
      '{4'hc, 2'h0, 40'hff_ffff_ffff, 40'h3, 40'hff_ffff_ffff, 40'hff_ffff_ffff},
      '{4'h2, 2'h0, 40'h10, 40'h7f, 40'hf, 40'hf},
      '{4'h3, 2'h0, 40'h10, 40'h7e, 40'h12, 40'h12},
      '{4'he, 2'h0, 40'h8000_0001, 40'h0, 40'h3, 40'h3},
      '{4'hf, 2'h0, 40'h3_0005, 40'h1, 40'h4_000b, 40'h4_000b},
      '{4'hd, 2'h1, 40'h80_0000_c000, 40'h0, 40'h80_0001_4000, 40'h80_0001_4000}};
    repeat (11) @(posedge core_clk);
    chk(res_valid_r, 1'b0);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'h00, d);
    chk(d, `ACR_ST_RESET);
    // reserved bits go back exactly as they were read
    wr(8'h00, d | `ACR_ST_WMASK);
    rd(8'h00, d);
    chk(d, `ACR_ST_WMASK);
    rd(8'h10, d);
    chk(d, 32'h0);
    for (int i = 0; i < 26; i++) begin
      for (int m = 0; m < 2; m++) begin
        wr(8'h00, {23'h0, m == 1, 8'h0});
        op(rows[i].c, rows[i].r, rows[i].a, rows[i].b);
        chk(round_sum_r, m ? rows[i].sb : rows[i].su);
        chk(res_half_r, half_of(rows[i].r, m ? rows[i].sb : rows[i].su));
        chk(res_valid_r, 1'b1);
        chk(acc_wr_r, rows[i].c == 4'h4);
        if (rows[i].c == 4'h4) chk(acc_out_r, rows[i].su);
        if (rows[i].r == 2'h0) chk(res_full_r, rows[i].su);
        else if (rows[i].c == 4'hd) chk(res_full_r, rows[i].a);
      end
    end
    op(4'h1, 2'h0, 40'h0, 40'h1);
    chk(condition_code_flag_r, 1'b1);
    op(4'h1, 2'h0, 40'h1, 40'h0);
    chk(condition_code_flag_r, 1'b0);
    // 16-bit width so a small add overflows
    op_width <= 2'h0;
    op(4'h0, 2'h0, 40'h7fff, 40'h1);
    chk(res_full_r, 40'hff_ffff_8000);
    op(4'h0, 2'h0, 40'h1, 40'h1);
    rd(8'h00, d);
    chk(d[13:12], 2'h2);
    op_sat <= 1'b1;
    op(4'h0, 2'h0, 40'h7fff, 40'h1);
    chk(res_full_r, 40'h00_0000_7fff);
    op_width <= 2'h1;
    op(4'h0, 2'h0, 40'h7fff_ffff, 40'h1);
    chk(res_full_r, 40'h00_7fff_ffff);
    op_width <= 2'h0;
    op_sat <= 1'b0;
    op_alu1 <= 1'b1;
    also_wr = 1'b1;
    op(4'h0, 2'h0, 40'h7fff, 40'h1);
    also_wr = 1'b0;
    rd(8'h00, d);
    chk(d[15:14], 2'h3);
    wr(8'h00, 32'h0);
    rd(8'h00, d);
    chk(d[15:12], 4'h0);
    close_out;
  end
endmodule
